// ### hw/mcb_decoder.sv
// Purpose: Command block decoder with AXI4-Lite access to command and status words
// Assumes: Host writes command words through the bus, single clock
// Notes:   Moves are latched for a motion engine; no motion is generated here
`timescale 1ns/100ps
// Function
// - Code 0200 presets motor position from position word, or encoder if bit 13.
// - Words a command does not use are ignored.
// - Position preset clears position-untrusted and motion-done flags.
// - Code 0400 resets errors and clears motion-done flag.
// - Error reset leaves position-untrusted and setup-fault flags alone.
// - Code 2000 starts assembled move; bit 9 picks blend or dwell.
// - Assembled move direction comes from second word bit 4.
// - Dwell variant takes dwell milliseconds from rate-change word.
// - Code 4000 presets encoder count from position word, clamped.
// - Both variants share programming; choice made only at start.
// - Programming-start block sets status bits 8 and 9.
// - Segment block 1800 carries target, speed, ramps and rate-change value.
// - Bit 12 seen while programming accepts segment, clears status bit 9.
// - Device sets status bit 9 again after host clears bit 12.
// - At most sixteen segments stored per assembled move.
// - Status bit 9 means ready for next segment.
// - Status bit 8 means assembled programming mode.
// - Preset or reset sets acknowledge; cleared when host clears command.
module mcb_decoder
	import mcb_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// AXI4-Lite write address and data
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Move start to motion engine
	output logic             move_start_ff,
	output logic             move_dwell_ff,
	output logic             move_dir_ff,
	output logic [15:0]      move_dwell_ms_ff
);

	// ****************************************
	// Functions
	// ****************************************
	function automatic logic [31:0] clamp_pos(input logic [31:0] v);
		logic signed [31:0] s;
		s = signed'(v);
		if (s < POS_MIN) begin
			clamp_pos = POS_MIN;
		end else if (s > POS_MAX) begin
			clamp_pos = POS_MAX;
		end else begin
			clamp_pos = v;
		end
	endfunction : clamp_pos

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] st);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		merge = r;
	endfunction : merge

	// ****************************************
	// Storage
	// ****************************************
	logic [15:0] cmd0_ff, cmd1_ff, prev_cmd0_ff;
	logic [31:0] posw_ff, vel_ff, accdec_ff, curjerk_ff;
	logic [31:0] mpos_ff, epos_ff;
	logic        asm_mode_ff, wait_seg_ff, move_done_ff, pos_inv_ff, cfg_err_ff;
	logic        cmd_err_ff, ack_ff;
	logic [4:0]  seg_cnt_ff;
	mcb_prog_t   prog_ff;
	logic [31:0] seg_pos [SEG_MAX];
	logic [31:0] seg_vel [SEG_MAX];
	logic [31:0] seg_ramp [SEG_MAX];
	logic [15:0] seg_rate [SEG_MAX];
	logic [7:0]  aw_addr_ff;
	logic        aw_have_ff, w_have_ff;
	logic [31:0] w_data_ff;
	logic [3:0]  w_strb_ff;
	logic        wr_go, wr_hit, set_wr;
	logic        new_cmd;
	logic        seg_ok;

	// ****************************************
	// AXI write channel
	// ****************************************
	assign wr_go = aw_have_ff && w_have_ff && !s_axi_bvalid;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			aw_have_ff    <= 1'b0;
			aw_addr_ff    <= 8'h00;
			s_axi_awready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_have_ff && !s_axi_awready;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_ff <= 1'b1;
				aw_addr_ff <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_have_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			w_have_ff    <= 1'b0;
			w_data_ff    <= 32'h0000_0000;
			w_strb_ff    <= 4'h0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_wready <= !w_have_ff && !s_axi_wready;
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_ff <= 1'b1;
				w_data_ff <= s_axi_wdata;
				w_strb_ff <= s_axi_wstrb;
			end else if (wr_go) begin
				w_have_ff <= 1'b0;
			end
		end
	end

	always_comb begin
		case (aw_addr_ff)
			REG_CMD0, REG_CMD1, REG_POSW, REG_VEL, REG_ACCDEC, REG_CURJERK,
			REG_MPOS, REG_EPOS, REG_FLAGSET: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end
	assign set_wr = wr_go && wr_hit;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ****************************************
	// Command block words
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cmd0_ff    <= CMD_NONE;
			cmd1_ff    <= CMD_NONE;
			posw_ff    <= 32'h0000_0000;
			vel_ff     <= 32'h0000_0000;
			accdec_ff  <= 32'h0000_0000;
			curjerk_ff <= 32'h0000_0000;
		end else if (set_wr) begin
			case (aw_addr_ff)
				REG_CMD0:    cmd0_ff    <= 16'(merge({16'h0000, cmd0_ff}, w_data_ff, w_strb_ff));
				REG_CMD1:    cmd1_ff    <= 16'(merge({16'h0000, cmd1_ff}, w_data_ff, w_strb_ff));
				REG_POSW:    posw_ff    <= merge(posw_ff, w_data_ff, w_strb_ff);
				REG_VEL:     vel_ff     <= merge(vel_ff, w_data_ff, w_strb_ff);
				REG_ACCDEC:  accdec_ff  <= merge(accdec_ff, w_data_ff, w_strb_ff);
				REG_CURJERK: curjerk_ff <= merge(curjerk_ff, w_data_ff, w_strb_ff);
				default:     cmd0_ff    <= cmd0_ff;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			prev_cmd0_ff <= CMD_NONE;
		end else begin
			prev_cmd0_ff <= cmd0_ff;
		end
	end
	assign new_cmd = cmd0_ff != prev_cmd0_ff;

	// ****************************************
	// Presets and flags
	// ****************************************
	// preset from position word
	always_ff @(posedge clk) begin
		if (!rstn) begin
			mpos_ff <= 32'h0000_0000;
			epos_ff <= 32'h0000_0000;
		end else if (new_cmd && cmd0_ff == CMD_PRESET_POS) begin
			mpos_ff <= cmd1_ff[USE_ENC_BIT] ? epos_ff : clamp_pos(posw_ff);
		end else if (new_cmd && cmd0_ff == CMD_PRESET_ENC) begin
			epos_ff <= clamp_pos(posw_ff);
		end else if (set_wr && aw_addr_ff == REG_MPOS) begin
			mpos_ff <= merge(mpos_ff, w_data_ff, w_strb_ff);
		end else if (set_wr && aw_addr_ff == REG_EPOS) begin
			epos_ff <= merge(epos_ff, w_data_ff, w_strb_ff);
		end
	end

	// flag effects; set wins over clear
	always_ff @(posedge clk) begin
		if (!rstn) begin
			pos_inv_ff   <= 1'b1;
			move_done_ff <= 1'b0;
			cmd_err_ff   <= 1'b0;
			cfg_err_ff   <= 1'b0;
		end else if (set_wr && aw_addr_ff == REG_FLAGSET) begin
			pos_inv_ff   <= w_data_ff[ST0_POS_INVALID];
			move_done_ff <= w_data_ff[ST0_MOVE_DONE];
		end else if (new_cmd) begin
			case (cmd0_ff)
				CMD_PRESET_POS: begin
					pos_inv_ff   <= 1'b0;
					move_done_ff <= 1'b0;
				end
				CMD_RESET_ERR: begin
					move_done_ff <= 1'b0;
					cmd_err_ff   <= 1'b0;
				end
				CMD_RUN_ASM: move_done_ff <= 1'b0;
				CMD_PRESET_ENC, CMD_PROG_START, CMD_SEGMENT, CMD_NONE: cmd_err_ff <= cmd_err_ff;
				default: begin
					if (!(asm_mode_ff && cmd0_ff[SEG_STROBE_BIT] == 1'b0)) begin
						cmd_err_ff <= 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			ack_ff <= 1'b0;
		end else if (new_cmd && (cmd0_ff == CMD_PRESET_POS || cmd0_ff == CMD_RESET_ERR ||
			cmd0_ff == CMD_PRESET_ENC)) begin
			ack_ff <= 1'b1;
		end else if (cmd0_ff == CMD_NONE) begin
			ack_ff <= 1'b0;
		end
	end

	// ****************************************
	// Assembled move programming
	// ****************************************
	assign seg_ok = seg_cnt_ff < 5'(SEG_MAX);

	always_ff @(posedge clk) begin
		if (!rstn) begin
			prog_ff     <= MCB_IDLE;
			asm_mode_ff <= 1'b0;
			wait_seg_ff <= 1'b0;
			seg_cnt_ff  <= 5'h00;
		end else begin
			case (prog_ff)
				MCB_IDLE: begin
					if (new_cmd && cmd0_ff == CMD_PROG_START) begin
						prog_ff     <= MCB_WAIT_SEG;
						asm_mode_ff <= 1'b1;
						wait_seg_ff <= 1'b1;
						seg_cnt_ff  <= 5'h00;
					end
				end
				MCB_WAIT_SEG: begin
					if (cmd0_ff[SEG_STROBE_BIT]) begin
						prog_ff     <= MCB_WAIT_REL;
						wait_seg_ff <= 1'b0;
						if (seg_ok) begin
							seg_cnt_ff <= seg_cnt_ff + 5'h01;
						end
					end else if (new_cmd && cmd0_ff != CMD_PROG_START &&
						cmd0_ff[11] == 1'b0) begin
						prog_ff     <= MCB_IDLE;
						asm_mode_ff <= 1'b0;
						wait_seg_ff <= 1'b0;
					end
				end
				MCB_WAIT_REL: begin
					if (!cmd0_ff[SEG_STROBE_BIT]) begin
						prog_ff     <= MCB_WAIT_SEG;
						wait_seg_ff <= 1'b1;
					end
				end
				default: prog_ff <= MCB_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (prog_ff == MCB_WAIT_SEG && cmd0_ff[SEG_STROBE_BIT] && seg_ok) begin
			seg_pos[seg_cnt_ff[3:0]]  <= clamp_pos(posw_ff);
			seg_vel[seg_cnt_ff[3:0]]  <= (vel_ff > SPEED_MAX) ? SPEED_MAX : vel_ff;
			seg_ramp[seg_cnt_ff[3:0]] <= accdec_ff;
			seg_rate[seg_cnt_ff[3:0]] <= (curjerk_ff[31:16] > RAMP_MAX) ? RAMP_MAX :
				curjerk_ff[31:16];
		end
	end

	// ****************************************
	// Run assembled move
	// ****************************************
	// variant chosen at start
	always_ff @(posedge clk) begin
		if (!rstn) begin
			move_start_ff    <= 1'b0;
			move_dwell_ff    <= 1'b0;
			move_dir_ff      <= 1'b0;
			move_dwell_ms_ff <= 16'h0000;
		end else begin
			move_start_ff <= new_cmd && cmd0_ff == CMD_RUN_ASM;
			if (new_cmd && cmd0_ff == CMD_RUN_ASM) begin
				move_dwell_ff    <= cmd1_ff[DWELL_SEL_BIT];
				move_dir_ff      <= cmd1_ff[DIR_BIT];
				move_dwell_ms_ff <= cmd1_ff[DWELL_SEL_BIT] ? curjerk_ff[31:16] : 16'h0000;
			end
		end
	end

	// ****************************************
	// AXI read channel
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rstn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= RESP_OKAY;
				case (s_axi_araddr)
					REG_CMD0:    s_axi_rdata <= {16'h0000, cmd0_ff};
					REG_CMD1:    s_axi_rdata <= {16'h0000, cmd1_ff};
					REG_POSW:    s_axi_rdata <= posw_ff;
					REG_VEL:     s_axi_rdata <= vel_ff;
					REG_ACCDEC:  s_axi_rdata <= accdec_ff;
					REG_CURJERK: s_axi_rdata <= curjerk_ff;
					REG_STAT: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rdata[16 + ST1_CMD_ACK] <= ack_ff;
						s_axi_rdata[ST0_CFG_ERR]      <= cfg_err_ff;
						s_axi_rdata[SEG_STROBE_BIT]   <= cmd_err_ff;
						s_axi_rdata[ST0_POS_INVALID]  <= pos_inv_ff;
						s_axi_rdata[ST0_WAIT_SEG]     <= wait_seg_ff;
						s_axi_rdata[ST0_ASM_MODE]     <= asm_mode_ff;
						s_axi_rdata[ST0_MOVE_DONE]    <= move_done_ff;
					end
					REG_MPOS:   s_axi_rdata <= mpos_ff;
					REG_EPOS:   s_axi_rdata <= epos_ff;
					REG_MOVE:   s_axi_rdata <= {move_dwell_ms_ff, 14'h0000, move_dir_ff,
						move_dwell_ff};
					REG_SEGCNT: s_axi_rdata <= {27'h0000000, seg_cnt_ff};
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule : mcb_decoder

// ### common/mcb_pkg.sv
// Purpose: Constants for the motion command block decoder
// Assumes: Command block words as 16/32-bit fields, AXI4-Lite 32-bit registers
// Notes:   One aligned word per register
package mcb_pkg;
	// ****************************************
	// Command codes
	// ****************************************
	localparam logic [15:0] CMD_PRESET_POS  = 16'h0200;
	localparam logic [15:0] CMD_RESET_ERR   = 16'h0400;
	localparam logic [15:0] CMD_PROG_START  = 16'h0800;
	localparam logic [15:0] CMD_SEGMENT     = 16'h1800;
	localparam logic [15:0] CMD_RUN_ASM     = 16'h2000;
	localparam logic [15:0] CMD_PRESET_ENC  = 16'h4000;
	localparam logic [15:0] CMD_NONE        = 16'h0000;
	// ****************************************
	// Bit positions
	// ****************************************
	localparam int SEG_STROBE_BIT  = 12;
	localparam int USE_ENC_BIT     = 13;
	localparam int DWELL_SEL_BIT   = 9;
	localparam int DIR_BIT         = 4;
	localparam int ST0_WAIT_SEG    = 9;
	localparam int ST0_ASM_MODE    = 8;
	localparam int ST0_MOVE_DONE   = 7;
	localparam int ST0_POS_INVALID = 10;
	localparam int ST0_CFG_ERR     = 13;
	localparam int ST1_CMD_ACK     = 13;
	// ****************************************
	// Limits
	// ****************************************
	localparam logic signed [31:0] POS_MIN   = 32'shff80_0000;
	localparam logic signed [31:0] POS_MAX   = 32'sh007f_ffff;
	localparam logic [31:0]        SPEED_MAX = 32'h002d_c6bf;
	localparam logic [15:0]        RAMP_MIN  = 16'h0001;
	localparam logic [15:0]        RAMP_MAX  = 16'h1388;
	localparam int                 SEG_MAX   = 16;
	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [7:0] REG_CMD0    = 8'h00;
	localparam logic [7:0] REG_CMD1    = 8'h04;
	localparam logic [7:0] REG_POSW    = 8'h08;
	localparam logic [7:0] REG_VEL     = 8'h0c;
	localparam logic [7:0] REG_ACCDEC  = 8'h10;
	localparam logic [7:0] REG_CURJERK = 8'h14;
	localparam logic [7:0] REG_STAT    = 8'h18;
	localparam logic [7:0] REG_MPOS    = 8'h1c;
	localparam logic [7:0] REG_EPOS    = 8'h20;
	localparam logic [7:0] REG_MOVE    = 8'h24;
	localparam logic [7:0] REG_SEGCNT  = 8'h28;
	localparam logic [7:0] REG_FLAGSET = 8'h2c;
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef enum logic [1:0] {MCB_IDLE, MCB_WAIT_SEG, MCB_WAIT_REL} mcb_prog_t;
endpackage : mcb_pkg

// ### verification/mcb_decoder_props.sv
// Purpose: Concurrent checks on move outputs and bus answers
// Assumes: Full byte strobes on every write
// Notes:   Command words are shadowed from bus traffic
`timescale 1ns/100ps
module mcb_decoder_props
	import mcb_pkg::*;
(
	// Clock and reset
	input wire logic        clk,
	input wire logic        rstn,
	// Bus
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	// Move outputs
	input wire logic        move_start_ff,
	input wire logic        move_dwell_ff,
	input wire logic        move_dir_ff,
	input wire logic [15:0] move_dwell_ms_ff
);
	// ****************************************
	// Shadow of written words
	// ****************************************
	logic [7:0]  a_ff;
	logic [31:0] d_ff;
	logic [15:0] cmd0_ff;
	logic [15:0] cmd1_ff;
	logic [15:0] jerk_ff;
	logic [2:0]  since_run_ff;
	logic        commit;
	logic        run_now;
	assign commit = s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_OKAY;
	assign run_now = commit && a_ff == REG_CMD0 && d_ff[15:0] == CMD_RUN_ASM
		&& cmd0_ff != CMD_RUN_ASM;
	always_ff @(posedge clk) begin
		if (!rstn) begin
			a_ff <= 8'h00;
			d_ff <= 32'h0000_0000;
			cmd0_ff <= 16'h0000;
			cmd1_ff <= 16'h0000;
			jerk_ff <= 16'h0000;
		end else begin
			if (s_axi_awvalid && s_axi_awready)
				a_ff <= s_axi_awaddr;
			if (s_axi_wvalid && s_axi_wready)
				d_ff <= s_axi_wdata;
			if (commit && a_ff == REG_CMD0)
				cmd0_ff <= d_ff[15:0];
			if (commit && a_ff == REG_CMD1)
				cmd1_ff <= d_ff[15:0];
			if (commit && a_ff == REG_CURJERK)
				jerk_ff <= d_ff[31:16];
		end
	end
	always_ff @(posedge clk) begin
		if (!rstn)
			since_run_ff <= 3'h7;
		else if (run_now)
			since_run_ff <= 3'h0;
		else if (since_run_ff != 3'h7)
			since_run_ff <= since_run_ff + 3'h1;
	end
	// ****************************************
	// Properties
	// ****************************************
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence s_run_issued;
		run_now;
	endsequence
	sequence s_start_soon;
		##[0:3] move_start_ff;
	endsequence
	AST_RUN_START: assert property (s_run_issued |-> s_start_soon)
		else $error("run command gave no start pulse");
	AST_RUN_DIR: assert property (s_run_issued |-> ##[0:3]
		(move_start_ff && move_dir_ff == cmd1_ff[DIR_BIT]))
		else $error("move direction wrong");
	AST_RUN_VARIANT: assert property (s_run_issued |-> ##[0:3]
		(move_start_ff && move_dwell_ff == cmd1_ff[DWELL_SEL_BIT]))
		else $error("move variant wrong");
	AST_RUN_DWELL_MS: assert property (s_run_issued |-> ##[0:3] (move_start_ff &&
		move_dwell_ms_ff == (cmd1_ff[DWELL_SEL_BIT] ? jerk_ff : 16'h0000)))
		else $error("dwell time wrong");
	AST_PULSE_ONCE: assert property (move_start_ff |=> !move_start_ff)
		else $error("start pulse longer than one cycle");
	AST_LATCH_HOLD: assert property (!move_start_ff |->
		$stable({move_dwell_ff, move_dir_ff, move_dwell_ms_ff}))
		else $error("move latch changed without start");
	AST_NO_SPURIOUS: assert property ($rose(move_start_ff) |->
		(run_now || since_run_ff <= 3'h3))
		else $error("start pulse without run command");
	AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
endmodule : mcb_decoder_props

bind mcb_decoder mcb_decoder_props i_mcb_decoder_props (
	.clk(clk), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
	.move_start_ff(move_start_ff), .move_dwell_ff(move_dwell_ff),
	.move_dir_ff(move_dir_ff), .move_dwell_ms_ff(move_dwell_ms_ff)
);

// ### verification/mcb_host.sv
// Purpose: Host model writing command blocks over AXI4-Lite
// Assumes: One transfer at a time, full byte strobes
// Notes:   Released lines show the inverse of the last value
`timescale 1ns/100ps
module mcb_host
	import mcb_pkg::*;
(
	// Clock
	input wire logic        clk,
	// Write side
	output logic [7:0]      s_axi_awaddr = 8'h00,
	output logic            s_axi_awvalid = 1'b0,
	input wire logic        s_axi_awready,
	output logic [31:0]     s_axi_wdata = 32'h0000_0000,
	output logic [3:0]      s_axi_wstrb = 4'hf,
	output logic            s_axi_wvalid = 1'b0,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	output logic            s_axi_bready = 1'b0,
	// Read side
	output logic [7:0]      s_axi_araddr = 8'h00,
	output logic            s_axi_arvalid = 1'b0,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	output logic            s_axi_rready = 1'b0
);
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ad;
		logic wd;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge clk);
			if (!ad && s_axi_awready) begin
				ad = 1'b1;
				s_axi_awvalid <= 1'b0;
				s_axi_awaddr <= ~a;
			end
			if (!wd && s_axi_wready) begin
				wd = 1'b1;
				s_axi_wvalid <= 1'b0;
				s_axi_wdata <= ~d;
			end
		end
		do @(posedge clk); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		s_axi_araddr <= ~a;
		do @(posedge clk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd
	task automatic seg(input logic [31:0] p, v, input logic [15:0] ac, dc, jk);
		logic [31:0] s;
		logic [1:0]  r;
		do rd(REG_STAT, s, r); while (s[9:8] !== 2'b11);
		wr(REG_POSW, p, r);
		wr(REG_VEL, v, r);
		wr(REG_ACCDEC, {dc, ac}, r);
		wr(REG_CURJERK, {jk, 16'h0000}, r);
		wr(REG_CMD0, {16'h0000, CMD_SEGMENT}, r);
		do rd(REG_STAT, s, r); while (s[9] !== 1'b0);
		wr(REG_CMD0, {16'h0000, CMD_PROG_START}, r);
	endtask : seg
endmodule : mcb_host

// ### verification/mcb_decoder_tb.sv
// Purpose: Self-checking bench for the command block decoder
// Assumes: Host model drives the bus
// Notes:   Seeded random values mixed with boundary cases
`timescale 1ns/100ps
module mcb_decoder_tb
	import mcb_pkg::*;
;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, v, d, n, starts = 0;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        move_start_ff, move_dwell_ff, move_dir_ff;
	logic [15:0] move_dwell_ms_ff, jk, c1;
	logic [17:0] seen;
	logic [31:0] vals [5];
	int          seed = 26, num_errors = 0, tests_run = 0, cycles = 0;
	mcb_decoder i_mcb_decoder (.clk(clk), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.move_start_ff(move_start_ff), .move_dwell_ff(move_dwell_ff),
		.move_dir_ff(move_dir_ff), .move_dwell_ms_ff(move_dwell_ms_ff));
	mcb_host i_mcb_host (.clk(clk), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
	// ****************************************
	// Helpers
	// ****************************************
	initial begin
		forever #2 clk = ~clk;
	end
	function automatic logic [31:0] clamp(input logic signed [31:0] x);
		return (x > POS_MAX) ? POS_MAX : ((x < POS_MIN) ? POS_MIN : x);
	endfunction : clamp
	function automatic logic [31:0] exp_move(input logic [15:0] c, ms);
		return {14'h0, (c[DWELL_SEL_BIT] ? ms : 16'h0000), c[DIR_BIT], c[DWELL_SEL_BIT]};
	endfunction : exp_move
	task automatic conclude();
		if (num_errors == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD at %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic w(input logic [7:0] a, input logic [31:0] x);
		logic [1:0] rr;
		i_mcb_host.wr(a, x, rr);
	endtask : w
	task automatic cmd(input logic [15:0] c);
		w(REG_CMD0, {16'h0000, c});
		repeat (3) @(posedge clk);
	endtask : cmd
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, e);
		logic [31:0] x;
		logic [1:0]  rr;
		i_mcb_host.rd(a, x, rr);
		chk(x & m, e);
	endtask : rd_chk
	always @(posedge clk) begin
		cycles++;
		if (move_start_ff === 1'b1) begin
			starts = starts + 1;
			seen = {move_dwell_ms_ff, move_dir_ff, move_dwell_ff};
		end
		if (cycles == 30000) begin
			num_errors++;
			conclude();
		end
	end
	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rd_chk(REG_STAT, 32'hffff_ffff, 32'h0000_0400);
		vals = '{32'h7fff_ffff, 32'h8000_0000, 32'h007f_ffff, 32'hff80_0000, 32'h0};
		vals[4] = $random(seed);
		foreach (vals[i]) begin
			v = vals[i];
			w(REG_FLAGSET, 32'h0000_0480);
			w(REG_VEL, $random(seed));
			w(REG_POSW, v);
			w(REG_CMD1, 32'h0);
			cmd(CMD_PRESET_POS);
			rd_chk(REG_MPOS, 32'hffff_ffff, clamp(v));
			rd_chk(REG_STAT, 32'h2000_0480, 32'h2000_0000);
			cmd(CMD_NONE);
			rd_chk(REG_STAT, 32'h2000_0000, 32'h0);
			cmd(CMD_PRESET_ENC);
			rd_chk(REG_EPOS, 32'hffff_ffff, clamp(v));
			cmd(CMD_NONE);
		end
		w(REG_POSW, 32'h0000_1234);
		w(REG_CMD1, 32'h0000_2000);
		cmd(CMD_PRESET_POS);
		rd_chk(REG_MPOS, 32'hffff_ffff, clamp(v));
		w(REG_POSW, 32'h0000_0055);
		cmd(CMD_PRESET_POS);
		rd_chk(REG_MPOS, 32'hffff_ffff, clamp(v));
		w(REG_FLAGSET, 32'h0000_0480);
		cmd(CMD_NONE);
		cmd(CMD_RESET_ERR);
		rd_chk(REG_STAT, 32'h2000_2480, 32'h2000_0400);
		cmd(CMD_NONE);
		cmd(CMD_PROG_START);
		rd_chk(REG_STAT, 32'h0000_0300, 32'h0000_0300);
		for (int i = 0; i < SEG_MAX; i++) begin
			d = $random(seed);
			i_mcb_host.seg({{9{d[22]}}, d[22:0]}, {$random(seed)} % (SPEED_MAX + 1),
				16'({$random(seed)} % 5000 + 1), 16'({$random(seed)} % 5000 + 1),
				16'({$random(seed)} % 5001));
		end
		repeat (3) @(posedge clk);
		rd_chk(REG_STAT, 32'h0000_0300, 32'h0000_0300);
		rd_chk(REG_SEGCNT, 32'hffff_ffff, 32'(SEG_MAX));
		for (int i = 0; i < 4; i++) begin
			jk = 16'($random(seed));
			c1 = 16'($random(seed));
			c1[DWELL_SEL_BIT] = i[0];
			c1[DIR_BIT] = i[1];
			cmd(CMD_NONE);
			n = starts;
			w(REG_CURJERK, {jk, 16'($random(seed))});
			w(REG_CMD1, {16'h0000, c1});
			cmd(CMD_RUN_ASM);
			repeat (4) @(posedge clk);
			chk({14'h0, seen}, exp_move(c1, jk));
			cmd(CMD_RUN_ASM);
			chk(starts - n, 32'h1);
		end
		i_mcb_host.rd(8'h30, d, r);
		chk(d, 32'h0);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		i_mcb_host.wr(8'h3c, 32'hffff_ffff, r);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		conclude();
	end
endmodule : mcb_decoder_tb
